/* File: rtl/adc_sequence_command_decode.sv */
/*
 * Serial control port command decoder with sequence-length configuration.
 * Assumes a host shifts 16-bit words MSB first on the serial clock while
 * chip select is low, and that the converter core reports on the system clock
 * whether a conversion sequence is running and supplies the result word.
 */
`include "seq_cmd_params.svh"

// Functional notes
// RULE1 - Code 10110 in bits 15:11 writes the sequence-length register.
// RULE2 - Bits 10:3 hold length minus one; 0 gives 1, 255 gives 256.
// RULE3 - A word with MSB 1 is a configuration-register write.
// RULE4 - A word with MSB 0 is a mode-control instruction.
// RULE5 - Mode instruction mid-sequence waits, then starts at next chip-select fall.
// RULE6 - Configuration write mid-sequence leaves the running scan settings untouched. Code holds only the length; other codes still pulse cfg_write_out.
// RULE7 - After mid-sequence configuration write, output data invalid until next mode instruction.
// RULE8 - Other configuration registers are selected by their own 5-bit codes.
// RULE9 - One 16-bit word per low chip select, MSB first, decoded at rise.
module adc_sequence_command_decode
	import seq_cmd_pkg::*;
(
	input  wire logic        mclk_in,           // System clock, 250 MHz.
	input  wire logic        rst_b_in,          // Active-low asynchronous reset.
	input  wire logic        serial_clk_in,     // Host serial clock pin.
	input  wire logic        chip_select_n_in,  // Host chip select pin, active low.
	input  wire logic        serial_data_in,    // Host serial data pin.
	input  wire logic        conv_active_in,    // Converter core sequence running.
	input  wire logic [15:0] result_word_in,    // Converter result for next frame.
	output logic             serial_data_out,   // Serial data to host.
	output logic             dout_valid_out,    // Serial output data is valid.
	output logic [7:0]       seq_len_out,       // Applied length minus one.
	output logic [7:0]       seq_len_staged_out,// Last written length minus one.
	output logic             mode_start_out,    // Pulse: mode instruction executes.
	output logic [15:0]      mode_word_out,     // Mode instruction word.
	output logic             cfg_write_out,     // Pulse: configuration write.
	output logic [4:0]       cfg_code_out,      // Configuration register code.
	output logic [10:0]      cfg_data_out       // Configuration payload bits.
);

	function automatic logic [4:0] reg_code(input ctl_word_t w);
		reg_code = w[`CODE_MSB:`CODE_LSB];
	endfunction : reg_code

	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_reg <= 1'h0;
			rst_sync_reg <= 1'h0;
		end else begin
			rst_meta_reg <= 1'h1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	logic [2:0] pins_sync;
	logic       s_sclk;
	logic       s_cs_n;
	logic       s_sdi;

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk_in  (mclk_in),
		.rst_b_in(rst_sync_reg),
		.pins_in ({serial_clk_in, chip_select_n_in, serial_data_in}),
		.sync_out(pins_sync)
	);

	assign s_sclk = pins_sync[2];
	assign s_cs_n = pins_sync[1];
	assign s_sdi  = pins_sync[0];

	frame_state_t state_reg,       state_next;
	logic         sclk_d_reg,      sclk_d_next;
	logic         cs_d_reg,        cs_d_next;
	ctl_word_t    rx_reg,          rx_next;
	ctl_word_t    tx_reg,          tx_next;
	logic [4:0]   bit_cnt_reg,     bit_cnt_next;
	logic         dout_reg,        dout_next;
	logic         valid_reg,       valid_next;
	logic [7:0]   len_reg,         len_next;
	logic [7:0]   staged_reg,      staged_next;
	logic         pending_reg,     pending_next;
	ctl_word_t    mode_word_reg,   mode_word_next;
	logic         mode_start_reg,  mode_start_next;
	logic         cfg_wr_reg,      cfg_wr_next;
	logic [4:0]   cfg_code_reg,    cfg_code_next;
	logic [10:0]  cfg_data_reg,    cfg_data_next;

	logic      sclk_rise;
	logic      sclk_fall;
	logic      cs_fall;
	logic      cs_rise;
	ctl_word_t word;

	assign sclk_rise = s_sclk & ~sclk_d_reg;
	assign sclk_fall = ~s_sclk & sclk_d_reg;
	assign cs_fall   = cs_d_reg & ~s_cs_n;
	assign cs_rise   = ~cs_d_reg & s_cs_n;
	assign word      = rx_reg;

	always_comb begin
		state_next      = state_reg;
		sclk_d_next     = s_sclk;
		cs_d_next       = s_cs_n;
		rx_next         = rx_reg;
		tx_next         = tx_reg;
		bit_cnt_next    = bit_cnt_reg;
		dout_next       = dout_reg;
		valid_next      = valid_reg;
		len_next        = len_reg;
		staged_next     = staged_reg;
		pending_next    = pending_reg;
		mode_word_next  = mode_word_reg;
		mode_start_next = 1'h0;
		cfg_wr_next     = 1'h0;
		cfg_code_next   = cfg_code_reg;
		cfg_data_next   = cfg_data_reg;
		case (state_reg)
			FRAME_IDLE: begin
				if (cs_fall) begin
					state_next   = FRAME_SHIFT;
					bit_cnt_next = `BIT_COUNT_RESET; // RULE9
					// Invalid frames shift out zeros so stale results never leak.
					tx_next      = valid_reg ? result_word_in : '0; // RULE7
					dout_next    = valid_reg ? result_word_in[`WORD_BITS-1] : 1'h0;
					if (pending_reg) begin
						pending_next    = 1'h0; // RULE5
						mode_start_next = 1'h1; // RULE5
						len_next        = staged_reg;
						valid_next      = 1'h1; // RULE7
						tx_next         = result_word_in;
						dout_next       = result_word_in[`WORD_BITS-1];
					end
				end
			end
			FRAME_SHIFT: begin
				if (sclk_rise && bit_cnt_reg != `BIT_COUNT_FULL) begin
					rx_next      = {rx_reg[`WORD_BITS-2:0], s_sdi}; // RULE9
					bit_cnt_next = bit_cnt_reg + 5'h01;
				end
				if (sclk_fall) begin
					tx_next   = {tx_reg[`WORD_BITS-2:0], 1'h0};
					dout_next = tx_reg[`WORD_BITS-2];
				end
				if (cs_rise) begin
					state_next = FRAME_IDLE;
					dout_next  = 1'h0;
					// A shorter frame is dropped whole; a longer one is decoded from its first 16 bits.
					if (bit_cnt_reg == `BIT_COUNT_FULL) begin // RULE9
						if (word[`CMD_KIND_BIT] == `KIND_CONFIG) begin // RULE3
							cfg_wr_next   = 1'h1; // RULE8
							cfg_code_next = reg_code(word); // RULE8
							cfg_data_next = word[`CFG_DATA_MSB:`CFG_DATA_LSB];
							if (reg_code(word) == `SEQ_LEN_CODE) begin // RULE1
								staged_next = word[`SEQ_LEN_MSB:`SEQ_LEN_LSB]; // RULE2
								if (!conv_active_in) begin
									len_next = word[`SEQ_LEN_MSB:`SEQ_LEN_LSB]; // RULE2
								end
							end
							if (conv_active_in) begin
								valid_next = 1'h0; // RULE7
							end
						end else if (conv_active_in) begin // RULE4
							pending_next   = 1'h1; // RULE5
							mode_word_next = word;
						end else begin
							mode_start_next = 1'h1; // RULE4
							mode_word_next  = word;
							len_next        = staged_reg; // RULE6
							valid_next      = 1'h1; // RULE7
						end
					end
				end
			end
			default: begin
				state_next = FRAME_IDLE;
			end
		endcase
	end

	// Running sequence keeps len_reg; a mode instruction moves staged into it, and a length write while idle loads it directly.
	always_ff @(posedge mclk_in or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg      <= FRAME_IDLE;
			sclk_d_reg     <= 1'h0;
			// The synchroniser leaves reset showing chip select low, so the edge
			// history starts low too; otherwise a false frame opens after reset.
			cs_d_reg       <= 1'h0;
			rx_reg         <= '0;
			tx_reg         <= '0;
			bit_cnt_reg    <= `BIT_COUNT_RESET;
			dout_reg       <= 1'h0;
			valid_reg      <= 1'h1;
			len_reg        <= `SEQ_LEN_RESET;
			staged_reg     <= `SEQ_LEN_RESET;
			pending_reg    <= 1'h0;
			mode_word_reg  <= '0;
			mode_start_reg <= 1'h0;
			cfg_wr_reg     <= 1'h0;
			cfg_code_reg   <= 5'h00;
			cfg_data_reg   <= 11'h000;
		end else begin
			state_reg      <= state_next;
			sclk_d_reg     <= sclk_d_next;
			cs_d_reg       <= cs_d_next;
			rx_reg         <= rx_next;
			tx_reg         <= tx_next;
			bit_cnt_reg    <= bit_cnt_next;
			dout_reg       <= dout_next;
			valid_reg      <= valid_next;
			len_reg        <= len_next; // RULE6
			staged_reg     <= staged_next;
			pending_reg    <= pending_next;
			mode_word_reg  <= mode_word_next;
			mode_start_reg <= mode_start_next;
			cfg_wr_reg     <= cfg_wr_next;
			cfg_code_reg   <= cfg_code_next;
			cfg_data_reg   <= cfg_data_next;
		end
	end

	assign serial_data_out    = dout_reg;
	assign dout_valid_out     = valid_reg;
	assign seq_len_out        = len_reg;
	assign seq_len_staged_out = staged_reg;
	assign mode_start_out     = mode_start_reg;
	assign mode_word_out      = mode_word_reg;
	assign cfg_write_out      = cfg_wr_reg;
	assign cfg_code_out       = cfg_code_reg;
	assign cfg_data_out       = cfg_data_reg;

endmodule : adc_sequence_command_decode

/* File: rtl/seq_cmd_params.svh */
/*
 * Constants for the serial command decoder: word layout, register select
 * codes, reset values and frame length.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SEQ_CMD_PARAMS_SVH
`define SEQ_CMD_PARAMS_SVH

`define WORD_BITS         16
`define CMD_KIND_BIT      15
`define CODE_MSB          15
`define CODE_LSB          11
`define SEQ_LEN_MSB       10
`define SEQ_LEN_LSB       3
`define CFG_DATA_MSB      10
`define CFG_DATA_LSB      0
`define KIND_CONFIG       1'h1
`define SEQ_LEN_CODE      5'h16
`define UPPER_SCAN_CODE   5'h14
`define SEQ_LEN_RESET     8'h00
`define BIT_COUNT_FULL    5'h10
`define BIT_COUNT_RESET   5'h00

`endif

/* File: rtl/seq_cmd_pkg.sv */
/*
 * Types shared by the serial command decoder.
 * Assumes seq_cmd_params.svh supplies the numeric constants.
 */
package seq_cmd_pkg;

	typedef enum logic [1:0] {
		FRAME_IDLE  = 2'b01,
		FRAME_SHIFT = 2'b10
	} frame_state_t;

	typedef logic [15:0] ctl_word_t;

endpackage : seq_cmd_pkg

/* File: rtl/pin_sync.sv */
/*
 * Two-flop synchroniser for a bundle of asynchronous pins.
 * Assumes each bit is an independent level; no bus coherence is given.
 */
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_in,   // Sampling clock.
	input  wire logic             rst_b_in, // Active-low asynchronous reset.
	input  wire logic [WIDTH-1:0] pins_in,  // Asynchronous levels.
	output logic      [WIDTH-1:0] sync_out  // Synchronised levels.
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= pins_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;

endmodule : pin_sync

/* File: sim/seq_cmd_checker_sva.sv */
/* Checker for the serial command decoder, bound to its top module.
 * Assumes mclk_in is the only clock and rst_b_in the raw low reset. */
module seq_cmd_checker (
	input wire logic        mclk_in,            // Clock.
	input wire logic        rst_b_in,           // Reset, low.
	input wire logic        chip_select_n_in,   // Frame select pin.
	input wire logic        conv_active_in,     // Sequence running.
	input wire logic        serial_data_out,    // Data to host.
	input wire logic        dout_valid_out,     // Output data valid.
	input wire logic        mode_start_out,     // Mode start pulse.
	input wire logic        cfg_write_out,      // Config write pulse.
	input wire logic [7:0]  seq_len_out,        // Applied length.
	input wire logic [7:0]  seq_len_staged_out, // Staged length.
	input wire logic [15:0] mode_word_out,      // Mode word.
	input wire logic [4:0]  cfg_code_out,       // Config code.
	input wire logic [10:0] cfg_data_out        // Config payload.
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence s_len_write;
		cfg_write_out && cfg_code_out == 5'h16;
	endsequence
	sequence s_dead_frame;
		$fell(chip_select_n_in) ##1 !dout_valid_out [*6];
	endsequence
	chk_mode_pulse: assert property (mode_start_out |=> !mode_start_out)
		else $error("mode start pulse too long");
	chk_cfg_kind: assert property (cfg_write_out |-> cfg_code_out[4] && !mode_start_out)
		else $error("config write without kind bit");
	chk_mode_kind: assert property (mode_start_out |-> !mode_word_out[15])
		else $error("mode start with kind bit set");
	chk_staged_load: assert property (s_len_write |-> seq_len_staged_out == cfg_data_out[10:3])
		else $error("staged length wrong");
	chk_start_copy: assert property (mode_start_out |-> dout_valid_out && seq_len_out == seq_len_staged_out)
		else $error("mode start did not apply length");
	chk_len_hold: assert property ($changed(seq_len_out) |-> mode_start_out || (cfg_write_out && !$past(conv_active_in)))
		else $error("applied length changed mid sequence");
	chk_busy_cfg: assert property (cfg_write_out && $past(conv_active_in) |-> !dout_valid_out)
		else $error("valid kept after busy config write");
	chk_valid_rise: assert property ($rose(dout_valid_out) |-> mode_start_out)
		else $error("valid rose without mode start");
	chk_zero_out: assert property (s_dead_frame |-> !serial_data_out)
		else $error("invalid data not zero");
	chk_decode_rise: assert property (cfg_write_out |-> $past(chip_select_n_in, 3))
		else $error("decode before frame end");
endmodule : seq_cmd_checker

bind adc_sequence_command_decode seq_cmd_checker u_chk (
	.mclk_in           (mclk_in),
	.rst_b_in          (rst_b_in),
	.chip_select_n_in  (chip_select_n_in),
	.conv_active_in    (conv_active_in),
	.serial_data_out   (serial_data_out),
	.dout_valid_out    (dout_valid_out),
	.mode_start_out    (mode_start_out),
	.cfg_write_out     (cfg_write_out),
	.seq_len_out       (seq_len_out),
	.seq_len_staged_out(seq_len_staged_out),
	.mode_word_out     (mode_word_out),
	.cfg_code_out      (cfg_code_out),
	.cfg_data_out      (cfg_data_out)
);

/* File: sim/host_spi_model.sv */
/* Host serial master: shifts words out MSB first and reads the reply.
 * Assumes the caller waits for reset release before the first frame. */
module host_spi_model (
	input  wire logic        mclk_in,  // Bench clock.
	input  wire logic        sdo_in,   // Data from device.
	output logic             sclk_out, // Serial clock.
	output logic             cs_n_out, // Frame select, low.
	output logic             sdi_out,  // Data to device.
	output logic [15:0]      rx_out    // Last reply.
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
		rx_out = 16'h0000;
	end
	// Six cycles per half period gives the 48 ns serial clock.
	task automatic send(input logic [15:0] w, input int n);
		@(posedge mclk_in) cs_n_out <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk_in) sdi_out <= w[15-i];
			repeat (5) @(posedge mclk_in);
			rx_out <= {rx_out[14:0], sdo_in};
			sclk_out <= 1'b1;
			repeat (6) @(posedge mclk_in);
			sclk_out <= 1'b0;
		end
		repeat (6) @(posedge mclk_in);
		cs_n_out <= 1'b1;
		// A released line must not keep its last value.
		sdi_out <= ~sdi_out;
		repeat (12) @(posedge mclk_in);
	endtask : send
endmodule : host_spi_model

/* File: sim/tb_top.sv */
/* Testbench for the serial command decoder.
 * Assumes the host model speaks the documented serial link. */
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk_in = 1'b0, rst_b_in = 1'b0, conv_active_in = 1'b0;
	logic        serial_clk_in, chip_select_n_in, serial_data_in, serial_data_out;
	logic        dout_valid_out, mode_start_out, cfg_write_out;
	logic [15:0] result_word_in = 16'hA5C3, mode_word_out, rx;
	logic [7:0]  seq_len_out, seq_len_staged_out;
	logic [4:0]  cfg_code_out;
	logic [10:0] cfg_data_out;
	int          fails = 0, check_count = 0, cycles = 0;
	int          starts = 0, cfg_writes = 0;
	always #2 mclk_in = ~mclk_in;
	adc_sequence_command_decode u_dut (
		.mclk_in           (mclk_in),
		.rst_b_in          (rst_b_in),
		.serial_clk_in     (serial_clk_in),
		.chip_select_n_in  (chip_select_n_in),
		.serial_data_in    (serial_data_in),
		.conv_active_in    (conv_active_in),
		.result_word_in    (result_word_in),
		.serial_data_out   (serial_data_out),
		.dout_valid_out    (dout_valid_out),
		.seq_len_out       (seq_len_out),
		.seq_len_staged_out(seq_len_staged_out),
		.mode_start_out    (mode_start_out),
		.mode_word_out     (mode_word_out),
		.cfg_write_out     (cfg_write_out),
		.cfg_code_out      (cfg_code_out),
		.cfg_data_out      (cfg_data_out)
	);
	// Pulses last one cycle, so they are counted as they pass.
	always @(posedge mclk_in) begin
		if (mode_start_out === 1'b1)
			starts <= starts + 1;
		if (cfg_write_out === 1'b1)
			cfg_writes <= cfg_writes + 1;
	end
	host_spi_model u_host (.mclk_in(mclk_in), .sdo_in(serial_data_out),
		.sclk_out(serial_clk_in), .cs_n_out(chip_select_n_in),
		.sdi_out(serial_data_in), .rx_out(rx));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		repeat (8) @(posedge mclk_in);
		chk({8'h00, seq_len_out}, 16'h0000);
		chk({15'h0000, dout_valid_out}, 16'h0001);
		u_host.send(16'hB7F8, 16);
		chk({8'h00, seq_len_staged_out}, 16'h00FF);
		chk({8'h00, seq_len_out}, 16'h00FF);
		chk({11'h000, cfg_code_out}, 16'h0016);
		u_host.send(16'h0800, 16);
		chk(mode_word_out, 16'h0800);
		chk(rx, 16'hA5C3);
		conv_active_in <= 1'b1;
		u_host.send(16'hA3F8, 16);
		chk({11'h000, cfg_code_out}, 16'h0014);
		chk({5'h00, cfg_data_out}, 16'h03F8);
		chk({8'h00, seq_len_staged_out}, 16'h00FF);
		chk({15'h0000, dout_valid_out}, 16'h0000);
		u_host.send(16'hB018, 16);
		chk({8'h00, seq_len_staged_out}, 16'h0003);
		chk({8'h00, seq_len_out}, 16'h00FF);
		u_host.send(16'h1000, 16);
		chk(rx, 16'h0000);
		chk({8'h00, seq_len_out}, 16'h00FF);
		chk({15'h0000, dout_valid_out}, 16'h0000);
		conv_active_in <= 1'b0;
		// A short frame is dropped, but its chip-select fall releases the held start.
		u_host.send(16'hB7F8, 8);
		chk({8'h00, seq_len_out}, 16'h0003);
		chk({8'h00, seq_len_staged_out}, 16'h0003);
		chk({15'h0000, dout_valid_out}, 16'h0001);
		chk(mode_word_out, 16'h1000);
		result_word_in <= 16'h3C5A;
		u_host.send(16'h0800, 16);
		chk(rx, 16'h3C5A);
		chk({8'h00, seq_len_out}, 16'h0003);
		chk(starts[15:0], 16'h0003);
		chk(cfg_writes[15:0], 16'h0003);
		summarize();
	end
endmodule : tb_top
